// File: rtl/conv_ctl_pkg.sv
// Behaviour
// [RULE1] pairing codes: free, parallel, fast, slow
// [RULE2] software zeroes pairing before changing it; the code does not check this
// [RULE3] pairing acts only in first instance
// [RULE4] channels per trigger equal split count plus one
// [RULE5] bit 11 enables split routine operation
// [RULE6] bit 8 enables sweep over channels
// [RULE7] bit 9 limits monitor0 to one channel
// [RULE8] channel pick 0..17, larger values reserved
// [RULE9] bit 23 enables monitor0 on routine channels
// [RULE10] bit 5 gates conversion done interrupt
// [RULE11] bit 6 gates monitor0 interrupt
// [RULE12] bit 30 gates monitor1 interrupt
// [RULE13] channels 16/17 route by instance
// [RULE14] control register resets to zero
// [RULE15] done flag set by hardware, cleared software
// [RULE16] interrupt when enabled flag is set
package conv_ctl_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] STAT_OFS = 8'h00;
  localparam logic [7:0] CTL0_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] RDATA_OFS = 8'h14;
  localparam logic [31:0] CTL0_RST = 32'h00000000;
  localparam logic [31:0] CTL0_WMASK = 32'h408feb7f;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MON1_IE_BIT = 30;
  localparam int MON0_RTN_BIT = 23;
  localparam int PAIR_LO = 16;
  localparam int SPLIT_LO = 13;
  localparam int SPLIT_EN_BIT = 11;
  localparam int MON0_SGL_BIT = 9;
  localparam int SWEEP_BIT = 8;
  localparam int MON0_IE_BIT = 6;
  localparam int DONE_IE_BIT = 5;
  localparam int FLAG_MON1_BIT = 30;
  localparam int FLAG_DONE_BIT = 1;
  localparam int FLAG_MON0_BIT = 0;
  localparam logic [4:0] CHAN_MAX = 5'h11;
  localparam logic [4:0] CHAN_TEMP = 5'h10;
  localparam logic [4:0] CHAN_REF = 5'h11;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    PAIR_FREE = 4'h0,
    PAIR_PAR = 4'h6,
    PAIR_FAST = 4'h7,
    PAIR_SLOW = 4'h8
  } pair_t;

  typedef enum logic [3:0] {
    MODE_FREE = 4'h1,
    MODE_PAR = 4'h2,
    MODE_FAST = 4'h4,
    MODE_SLOW = 4'h8
  } mode_t;

  typedef enum logic [1:0] {
    SRC_PIN = 2'h0,
    SRC_TEMP = 2'h1,
    SRC_REF = 2'h2,
    SRC_GND = 2'h3
  } src_t;

  typedef struct packed {
    logic sweep;
    logic split_en;
    logic [3:0] split_n;
    logic mon0_rtn;
    logic mon0_sgl;
    logic [4:0] mon0_pick;
    logic mon0_pick_ok;
  } seq_cfg_t;

endpackage

// File: rtl/conv_mode_decode.sv
module conv_mode_decode
  import conv_ctl_pkg::*;
(
  // code in
  input wire logic [3:0] code,
  input wire logic first_inst,
  // mode out
  output mode_t mode,
  output logic reserved
);

  // -------------------------------
  // decode
  // -------------------------------
  // second instance ignores the field entirely; reserved codes act as free
  wire logic [3:0] eff = first_inst ? code : PAIR_FREE; // [RULE3]
  assign reserved = !(eff == PAIR_FREE || eff == PAIR_PAR ||
                      eff == PAIR_FAST || eff == PAIR_SLOW);
  // [RULE1]
  assign mode = (eff == PAIR_PAR) ? MODE_PAR :
                (eff == PAIR_FAST) ? MODE_FAST :
                (eff == PAIR_SLOW) ? MODE_SLOW : MODE_FREE;

endmodule

// File: rtl/conv_ctl.sv
module conv_ctl
  import conv_ctl_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // instance strap
  input wire logic FIRST_INST,
  // axi4-lite write address
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // events from the conversion engine
  input wire logic SEQ_DONE,
  input wire logic MON0_EVENT,
  input wire logic MON1_EVENT,
  input wire logic [15:0] RESULT,
  // configuration out
  output mode_t PAIR_MODE,
  output logic PAIR_RESERVED,
  output seq_cfg_t SEQ_CFG,
  output src_t CH16_SRC,
  output src_t CH17_SRC,
  output logic IRQ
);

  // -------------------------------
  // state
  // -------------------------------
  logic [31:0] ctl0_ff;
  logic [31:0] stat_ff;
  logic [31:0] mask_ff;
  logic [7:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  mode_t mode_ff;
  logic reserved_ff;
  seq_cfg_t cfg_ff;
  src_t ch16_ff;
  src_t ch17_ff;
  logic irq_ff;
  // readies kept as flops of their own so no bus output leaves via logic
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;

  // -------------------------------
  // write channel handshake
  // -------------------------------
  // address and data are caught separately, in either order
  wire logic aw_take = AWVALID && !aw_held_ff;
  wire logic w_take = WVALID && !w_held_ff;
  wire logic wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  wire logic [31:0] bytemask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                                {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire logic wr_ctl0 = wr_fire && awaddr_ff == CTL0_OFS;
  wire logic wr_stat = wr_fire && awaddr_ff == STAT_OFS;
  wire logic wr_mask = wr_fire && awaddr_ff == MASK_OFS;
  wire logic wr_known = wr_ctl0 || wr_stat || wr_mask;

  // each ready mirrors its held flag, dropping on capture until the fire
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b1;
      w_held_ff <= 1'b0;
      wready_ff <= 1'b1;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (CE) begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
        awaddr_ff <= {AWADDR[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
        awready_ff <= 1'b1;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
        wready_ff <= 1'b1;
      end
    end
  end

  // response: slverr for unmapped offsets and for the read-only result offset
  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
    end else if (CE) begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? 2'b00 : 2'b10;
      end else if (BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // -------------------------------
  // control register
  // -------------------------------
  // reserved bits never store, so they read zero
  wire logic [31:0] ctl0_wm = bytemask & CTL0_WMASK;
  wire logic [31:0] nxt_ctl0 = (ctl0_ff & ~ctl0_wm) | (wdata_ff & ctl0_wm);

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctl0_ff <= CTL0_RST; // [RULE14]
    end else if (CE && wr_ctl0) begin
      ctl0_ff <= nxt_ctl0;
    end
  end

  // mask uses the status layout; only flag bits store
  wire logic [31:0] flag_bits = (32'h1 << FLAG_MON1_BIT) |
                                (32'h1 << FLAG_DONE_BIT) |
                                (32'h1 << FLAG_MON0_BIT);

  always_ff @(posedge CLK) begin
    if (RST) begin
      mask_ff <= 32'h00000000;
    end else if (CE && wr_mask) begin
      mask_ff <= (mask_ff & ~(bytemask & flag_bits)) |
                 (wdata_ff & bytemask & flag_bits);
    end
  end

  // -------------------------------
  // read channel
  // -------------------------------
  wire logic rd_take = ARVALID && !rvalid_ff;
  wire logic [7:0] rd_ofs = {ARADDR[7:2], 2'b00};
  wire logic rd_known = rd_ofs == STAT_OFS || rd_ofs == CTL0_OFS ||
                        rd_ofs == MASK_OFS || rd_ofs == RDATA_OFS;
  wire logic [31:0] rd_mux =
    (rd_ofs == STAT_OFS) ? stat_ff :
    (rd_ofs == CTL0_OFS) ? ctl0_ff :
    (rd_ofs == MASK_OFS) ? mask_ff :
    (rd_ofs == RDATA_OFS) ? {16'h0000, RESULT} : 32'h00000000;
  // reading the result clears the done flag
  wire logic rd_result = CE && rd_take && rd_ofs == RDATA_OFS;

  // one read at a time: address ready stays low while an answer waits
  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'b00;
    end else if (CE) begin
      if (rd_take) begin
        rvalid_ff <= 1'b1;
        arready_ff <= 1'b0;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_known ? 2'b00 : 2'b10;
      end else if (RREADY) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // -------------------------------
  // status flags
  // -------------------------------
  // writing zero clears a flag; a new event in that cycle still wins
  wire logic [31:0] set_vec = ({31'h0, SEQ_DONE} << FLAG_DONE_BIT) |
                              ({31'h0, MON0_EVENT} << FLAG_MON0_BIT) |
                              ({31'h0, MON1_EVENT} << FLAG_MON1_BIT);
  wire logic [31:0] clr_wr = wr_stat ? (bytemask & ~wdata_ff) : 32'h0;
  wire logic [31:0] clr_rd = rd_result ? (32'h1 << FLAG_DONE_BIT) : 32'h0;
  wire logic [31:0] nxt_stat =
    ((stat_ff & ~(clr_wr | clr_rd)) | set_vec) & flag_bits; // [RULE15]

  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_ff <= 32'h00000000;
    end else if (CE) begin
      stat_ff <= nxt_stat;
    end
  end

  // -------------------------------
  // interrupt
  // -------------------------------
  // control enables and mask both gate each flag
  wire logic done_irq = stat_ff[FLAG_DONE_BIT] && mask_ff[FLAG_DONE_BIT] &&
                        ctl0_ff[DONE_IE_BIT]; // [RULE10]
  wire logic mon0_irq = stat_ff[FLAG_MON0_BIT] && mask_ff[FLAG_MON0_BIT] &&
                        ctl0_ff[MON0_IE_BIT]; // [RULE11]
  wire logic mon1_irq = stat_ff[FLAG_MON1_BIT] && mask_ff[FLAG_MON1_BIT] &&
                        ctl0_ff[MON1_IE_BIT]; // [RULE12]

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else if (CE) begin
      irq_ff <= done_irq || mon0_irq || mon1_irq; // [RULE16]
    end
  end

  // -------------------------------
  // pairing decode
  // -------------------------------
  // limitation: no check that software passed through free between codes
  mode_t mode_w;
  logic reserved_w;

  conv_mode_decode u_dec (
    .code(ctl0_ff[PAIR_LO +: 4]),
    .first_inst(FIRST_INST),
    .mode(mode_w),
    .reserved(reserved_w)
  );

  // -------------------------------
  // sequencing and monitor config
  // -------------------------------
  wire logic [4:0] pick = ctl0_ff[4:0];
  seq_cfg_t nxt_cfg;
  assign nxt_cfg.sweep = ctl0_ff[SWEEP_BIT]; // [RULE6]
  assign nxt_cfg.split_en = ctl0_ff[SPLIT_EN_BIT]; // [RULE5]
  // count plus one channels per trigger
  assign nxt_cfg.split_n = {1'b0, ctl0_ff[SPLIT_LO +: 3]} + 4'h1; // [RULE4]
  assign nxt_cfg.mon0_rtn = ctl0_ff[MON0_RTN_BIT]; // [RULE9]
  // single-channel only matters while sweeping
  assign nxt_cfg.mon0_sgl = ctl0_ff[MON0_SGL_BIT] &&
                            ctl0_ff[SWEEP_BIT]; // [RULE7]
  assign nxt_cfg.mon0_pick = pick;
  assign nxt_cfg.mon0_pick_ok = pick <= CHAN_MAX; // [RULE8]

  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_ff <= MODE_FREE;
      reserved_ff <= 1'b0;
      cfg_ff <= '0;
      ch16_ff <= SRC_GND;
      ch17_ff <= SRC_GND;
    end else if (CE) begin
      mode_ff <= mode_w;
      reserved_ff <= reserved_w;
      cfg_ff <= nxt_cfg;
      ch16_ff <= FIRST_INST ? SRC_TEMP : SRC_GND; // [RULE13]
      ch17_ff <= FIRST_INST ? SRC_REF : SRC_GND; // [RULE13]
    end
  end

  // -------------------------------
  // outputs
  // -------------------------------
  assign AWREADY = awready_ff;
  assign WREADY = wready_ff;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;
  assign PAIR_MODE = mode_ff;
  assign PAIR_RESERVED = reserved_ff;
  assign SEQ_CFG = cfg_ff;
  assign CH16_SRC = ch16_ff;
  assign CH17_SRC = ch17_ff;
  assign IRQ = irq_ff;

endmodule

// File: tb/conv_ctl_monitor.sv
module conv_ctl_monitor
  import conv_ctl_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // strap and bus handshakes
  input wire logic FIRST_INST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  // configuration outputs
  input wire mode_t PAIR_MODE,
  input wire logic PAIR_RESERVED,
  input wire seq_cfg_t SEQ_CFG,
  input wire src_t CH16_SRC,
  input wire src_t CH17_SRC,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // both write halves taken at the same edge
  sequence wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence resp_soon;
    ##[1:3] BVALID;
  endsequence

  AST_RESET: assert property (
    $fell(RST) |-> !IRQ && SEQ_CFG == '0 && PAIR_MODE == MODE_FREE)
    else $error("reset values wrong");
  AST_SPLIT: assert property (
    !$past(RST) |-> SEQ_CFG.split_n != 4'h0)
    else $error("split count zero");
  AST_SGL: assert property (
    SEQ_CFG.mon0_sgl |-> SEQ_CFG.sweep)
    else $error("single channel without sweep");
  AST_PICK: assert property (
    !$past(RST) |-> SEQ_CFG.mon0_pick_ok == (SEQ_CFG.mon0_pick <= 5'h11))
    else $error("channel pick range wrong");
  AST_ONEHOT: assert property (
    $onehot(PAIR_MODE))
    else $error("pair mode not one-hot");
  AST_RSV: assert property (
    PAIR_RESERVED |-> PAIR_MODE == MODE_FREE)
    else $error("reserved code not free");
  AST_SECOND: assert property (
    !FIRST_INST && !$past(FIRST_INST) && !$past(RST) |->
      PAIR_MODE == MODE_FREE)
    else $error("second instance paired");
  AST_GND: assert property (
    !FIRST_INST && !$past(FIRST_INST) && !$past(RST) |->
      CH16_SRC == SRC_GND && CH17_SRC == SRC_GND)
    else $error("second instance inputs not ground");
  AST_INT: assert property (
    FIRST_INST && $past(FIRST_INST) && !$past(RST) |->
      CH16_SRC == SRC_TEMP && CH17_SRC == SRC_REF)
    else $error("first instance inputs wrong");
  AST_BRESP: assert property (
    wr_take |-> resp_soon)
    else $error("write response late");
endmodule

bind conv_ctl conv_ctl_monitor mon (
  .CLK, .RST, .FIRST_INST, .AWVALID, .AWREADY, .WVALID, .WREADY,
  .BVALID, .PAIR_MODE, .PAIR_RESERVED, .SEQ_CFG, .CH16_SRC,
  .CH17_SRC, .IRQ
);

// File: tb/test_conv_ctl.sv
module test_conv_ctl
  import conv_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and dut
  // ----------------------------------------
  logic CLK = 1'h0, RST = 1'h1, FIRST_INST = 1'h1;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
  logic ARVALID = 1'h0, RREADY = 1'h0;
  logic SEQ_DONE = 1'h0, MON0_EVENT = 1'h0, MON1_EVENT = 1'h0;
  logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
  logic [31:0] WDATA = 32'h0, RDATA, rd_v;
  logic [1:0] BRESP, RRESP, resp;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, PAIR_RESERVED;
  mode_t PAIR_MODE;
  seq_cfg_t SEQ_CFG;
  src_t CH16_SRC, CH17_SRC;
  int error_cnt = 0, checks = 0;
  logic [3:0] code[5] = '{4'h6, 4'h7, 4'h8, 4'h0, 4'hb};
  logic [3:0] mode[5] = '{4'h2, 4'h4, 4'h8, 4'h1, 4'h1};
  logic [31:0] flg[3] = '{32'h2, 32'h1, 32'h40000000};
  logic [31:0] ien[3] = '{32'h20, 32'h40, 32'h40000000};

  conv_ctl dut (
    .CLK, .RST, .CE(1'h1), .FIRST_INST, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB(4'hf), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .SEQ_DONE, .MON0_EVENT, .MON1_EVENT, .RESULT(16'h5a3c), .PAIR_MODE,
    .PAIR_RESERVED, .SEQ_CFG, .CH16_SRC, .CH17_SRC, .IRQ
  );

  // free-running bus clock
  always #5 CLK = ~CLK;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  // a hung handshake ends the run instead of spinning forever
  task automatic stall(input int n);
    if (n == 20) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // one idle edge at the end keeps ready drops apart from new requests
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
      if (BVALID) break;
    end
    resp = BRESP;
    BREADY <= 1'h0;
    stall(n);
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'h0;
      if (RVALID) break;
    end
    rd_v = RDATA;
    resp = RRESP;
    RREADY <= 1'h0;
    stall(n);
    @(posedge CLK);
  endtask

  task automatic cfg(input logic [31:0] w, input seq_cfg_t e);
    wr(CTL0_OFS, w);
    repeat (2) @(posedge CLK);
    check("seq cfg", 32'(e), 32'(SEQ_CFG));
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'h0;
    @(posedge CLK);
    rd(CTL0_OFS);
    check("ctl0 reset", 32'h0, rd_v);
    check("ctl0 rd resp", 32'h0, 32'(resp));
    wr(CTL0_OFS, 32'hffffffff);
    rd(CTL0_OFS);
    check("ctl0 bits", 32'h408feb7f, rd_v);
    // zero between codes, as software must
    foreach (code[i]) begin
      wr(CTL0_OFS, 32'h0);
      wr(CTL0_OFS, {12'h0, code[i], 16'h0});
      repeat (2) @(posedge CLK);
      check("pair mode", 32'(mode[i]), 32'(PAIR_MODE));
      check("pair rsv", 32'(i == 4), 32'(PAIR_RESERVED));
    end
    FIRST_INST <= 1'h0;
    repeat (2) @(posedge CLK);
    check("second mode", 32'h1, 32'(PAIR_MODE));
    check("second rsv", 32'h0, 32'(PAIR_RESERVED));
    check("second src", 32'hf, 32'({CH16_SRC, CH17_SRC}));
    FIRST_INST <= 1'h1;
    repeat (2) @(posedge CLK);
    check("first src", 32'h6, 32'({CH16_SRC, CH17_SRC}));
    cfg(32'h0080eb11, '{1, 1, 4'h8, 1, 1, 5'h11, 1});
    cfg(32'h00000212, '{0, 0, 4'h1, 0, 0, 5'h12, 0});
    cfg(32'h0000a110, '{1, 0, 4'h6, 0, 0, 5'h10, 1});
    wr(MASK_OFS, 32'h40000003);
    for (int i = 0; i < 3; i++) begin
      wr(CTL0_OFS, 32'h0);
      {MON1_EVENT, MON0_EVENT, SEQ_DONE} <= 3'(1 << i);
      @(posedge CLK);
      {MON1_EVENT, MON0_EVENT, SEQ_DONE} <= 3'h0;
      rd(STAT_OFS);
      check("flag", flg[i], rd_v);
      check("irq gated", 32'h0, 32'(IRQ));
      wr(CTL0_OFS, ien[i]);
      repeat (2) @(posedge CLK);
      check("irq on", 32'h1, 32'(IRQ));
      wr(MASK_OFS, 32'h0);
      repeat (2) @(posedge CLK);
      check("irq masked", 32'h0, 32'(IRQ));
      wr(MASK_OFS, 32'h40000003);
      wr(STAT_OFS, 32'h0);
      repeat (2) @(posedge CLK);
      check("irq cleared", 32'h0, 32'(IRQ));
    end
    SEQ_DONE <= 1'h1;
    @(posedge CLK);
    SEQ_DONE <= 1'h0;
    rd(RDATA_OFS);
    check("result", 32'h5a3c, rd_v);
    rd(STAT_OFS);
    check("done read clear", 32'h0, rd_v);
    wr(8'h08, 32'h1);
    check("unmapped wr", 32'h2, 32'(resp));
    rd(8'h08);
    check("unmapped rd", 32'h2, 32'(resp));
    wr(RDATA_OFS, 32'h1);
    check("ro wr", 32'h2, 32'(resp));
    give_verdict();
  end
endmodule
